// >>> logic/wdc_consts.svh
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH

// register byte offsets on the lite bus
`define WDC_OFF_CTRL        8'h00
`define WDC_OFF_CAUSE       8'h04
`define WDC_OFF_STAT        8'h08
`define WDC_OFF_MASK        8'h0C
`define WDC_OFF_CMD         8'h10

// field positions outside the control register
`define WDC_BIT_WATCHDOG_RESET_FLAG        3
`define WDC_BIT_EV_TIMEOUT  0
`define WDC_BIT_EV_RESET    1
`define WDC_BIT_RESTART     0
`define WDC_EV_W            2

// reset values
`define WDC_CTRL_RST        8'h00
`define WDC_EV_RST          2'h0

// timing: unlock window in core cycles, time-out base in oscillator cycles
`define WDC_UNLOCK_CYCLES   4
`define WDC_BASE_TIMEOUT    2048
`define WDC_CNT_W           21
`define WDC_MAX_PRESCALE    4'h9

// vector table entries
`define WDC_TIMEOUT_VEC_NUM  4'h9
`define WDC_TIMEOUT_VEC_ADDR 16'h0008
`define WDC_RESET_VEC_ADDR   16'h0000

// bus responses
`define WDC_RESP_OKAY       2'h0
`define WDC_RESP_SLVERR     2'h2

`endif

// >>> logic/wdc_pkg.sv
package wdc_pkg;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic       timeout_flag;
    logic       timeout_irq_enable;
    logic       prescale_hi;
    logic       change_unlock;
    logic       reset_enable;
    logic [2:0] prescale_lo;
  } wdc_ctrl_t;

  // from the processor core, same clock
  typedef struct packed {
    logic vector_ack;     // core enters the time-out vector
    logic restart;        // restart instruction executed
    logic global_irq_en;  // core's global interrupt flag
  } wdc_core_req_t;

  // to the processor core
  typedef struct packed {
    logic        irq_req;
    logic [3:0]  irq_vector_num;
    logic [15:0] irq_vector_addr;
    logic        sys_reset_req;
    logic [15:0] reset_vector_addr;
  } wdc_core_rsp_t;

  typedef enum logic [1:0] {
    MODE_STOPPED,
    MODE_IRQ,
    MODE_RESET,
    MODE_IRQ_RESET
  } wdc_mode_t;

endpackage

// >>> logic/wdc_timeout_counter.sv
`timescale 1ns/1ns
`include "wdc_consts.svh"

module wdc_timeout_counter import wdc_pkg::*; #(
  parameter int CNT_W = `WDC_CNT_W,
  parameter int BASE  = `WDC_BASE_TIMEOUT
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       osc_tick,
  input  wire logic       restart,
  input  wire logic [3:0] prescale_select,
  // event
  output logic            timeout
);

  logic [CNT_W-1:0] cnt_r;
  logic [3:0]       sel_eff;
  logic [CNT_W-1:0] limit;
  logic             expire;

  // reserved codes fall back to the longest defined time-out
  always_comb begin
    sel_eff = (prescale_select > `WDC_MAX_PRESCALE) ? `WDC_MAX_PRESCALE : prescale_select;
    limit   = CNT_W'(BASE) << sel_eff;
    // >= so that a shorter selection still expires at the next oscillator tick
    expire  = osc_tick && (cnt_r >= limit - CNT_W'(1));
  end

  // counts oscillator ticks; restart wins over counting
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (restart || expire) begin
      cnt_r <= '0;
    end else if (osc_tick) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // one-cycle time-out pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout <= 1'b0;
    end else begin
      timeout <= expire && !restart;
    end
  end

  AST_RESTART_ZEROES: assert property (@(posedge core_clk) disable iff (!rst_n)
    restart |=> (cnt_r == '0) && !timeout)
    else $error("counter not zero after restart");

  AST_RESERVED_LONGEST: assert property (@(posedge core_clk) disable iff (!rst_n)
    (prescale_select > `WDC_MAX_PRESCALE) |-> (limit == (CNT_W'(BASE) << `WDC_MAX_PRESCALE)))
    else $error("reserved prescale code not mapped to longest time-out");

endmodule

// >>> logic/wdc_watchdog.sv
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "wdc_consts.svh"

module wdc_watchdog import wdc_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int BASE   = `WDC_BASE_TIMEOUT
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // pins
  input  wire logic                wdt_osc_clk,
  input  wire logic                always_on_fuse,
  // processor core
  input  wire wdc_core_req_t       core_req,
  output wdc_core_rsp_t            core_rsp,
  // interrupt
  output logic                     irq_o
);

  logic                   osc_s1_r, osc_s2_r, osc_s3_r, fuse_s1_r, fuse_s2_r;
  logic                   osc_tick, fuse_prog, watchdog_reset_flag_r, eff_re, ie_eff;
  wdc_ctrl_t              ctrl_r, wd_ctrl;
  logic [2:0]             unlock_cnt_r;
  logic [`WDC_EV_W-1:0]   stat_r, mask_r;
  wdc_mode_t              mode;
  logic                   timeout, set_flag, fire_reset, cnt_restart;
  logic                   aw_held_r, w_held_r, aw_got, w_got, wr_go;
  logic [ADDR_W-1:0]      awaddr_r, wr_addr;
  logic [31:0]            wdata_r, wr_data, rd_data;
  logic [3:0]             wstrb_r, wr_strb;
  logic                   ctrl_wr, cause_wr, stat_wr, mask_wr, cmd_wr, rd_hit, wr_hit;

  // oscillator and fuse are pins: two flops first, edge found on the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      fuse_s1_r <= 1'b1;
      fuse_s2_r <= 1'b1;
    end else begin
      osc_s1_r  <= wdt_osc_clk;
      osc_s2_r  <= osc_s1_r;
      osc_s3_r  <= osc_s2_r;
      fuse_s1_r <= always_on_fuse;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  // core clock must be well above the oscillator for no tick to be lost
  assign osc_tick  = osc_s2_r && !osc_s3_r;
  assign fuse_prog = !fuse_s2_r;

  // effective enables and mode decode
  always_comb begin
    eff_re = ctrl_r.reset_enable || watchdog_reset_flag_r;
    ie_eff = ctrl_r.timeout_irq_enable && !fuse_prog;
    unique case ({fuse_prog, eff_re, ie_eff})
      3'b000:  mode = MODE_STOPPED;
      3'b001:  mode = MODE_IRQ;
      3'b010:  mode = MODE_RESET;
      3'b011:  mode = MODE_IRQ_RESET;
      default: mode = MODE_RESET;
    endcase
  end

  // time-out actions per mode
  always_comb begin
    set_flag   = timeout && ((mode == MODE_IRQ) ||
                 ((mode == MODE_IRQ_RESET) && !ctrl_r.timeout_flag));
    fire_reset = timeout && ((mode == MODE_RESET) ||
                 ((mode == MODE_IRQ_RESET) && ctrl_r.timeout_flag));
    cnt_restart = core_req.restart || (cmd_wr && wr_data[`WDC_BIT_RESTART]) ||
                  fire_reset || (mode == MODE_STOPPED);
  end

  wdc_timeout_counter #(
    .CNT_W (`WDC_CNT_W),
    .BASE  (BASE)
  ) i_wdc_timeout_counter (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .osc_tick        (osc_tick),
    .restart         (cnt_restart),
    .prescale_select ({ctrl_r.prescale_hi, ctrl_r.prescale_lo}),
    .timeout         (timeout)
  );

  // write path: address and data may arrive in either order
  always_comb begin
    aw_got  = aw_held_r || (s_axi_awvalid && s_axi_awready);
    w_got   = w_held_r || (s_axi_wvalid && s_axi_wready);
    wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    wr_data = w_held_r ? wdata_r : s_axi_wdata;
    wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
    wr_go   = aw_got && w_got;
    wd_ctrl = wdc_ctrl_t'(wr_data[7:0]);
    ctrl_wr  = wr_go && (wr_addr == `WDC_OFF_CTRL) && wr_strb[0];
    cause_wr = wr_go && (wr_addr == `WDC_OFF_CAUSE) && wr_strb[0];
    stat_wr  = wr_go && (wr_addr == `WDC_OFF_STAT) && wr_strb[0];
    mask_wr  = wr_go && (wr_addr == `WDC_OFF_MASK) && wr_strb[0];
    cmd_wr   = wr_go && (wr_addr == `WDC_OFF_CMD) && wr_strb[0];
    wr_hit   = (wr_addr == `WDC_OFF_CTRL) || (wr_addr == `WDC_OFF_CAUSE) ||
               (wr_addr == `WDC_OFF_STAT) || (wr_addr == `WDC_OFF_MASK) ||
               (wr_addr == `WDC_OFF_CMD);
  end

  // write channel handshakes and response
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDC_RESP_OKAY;
    end else if (s_axi_bvalid) begin
      if (s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end else if (wr_go) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b1;
      s_axi_bresp   <= wr_hit ? `WDC_RESP_OKAY : `WDC_RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
    end
  end

  // control register; the flag's hardware set beats every clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= wdc_ctrl_t'(`WDC_CTRL_RST);
    end else if (fire_reset) begin
      // system goes down; reset enable stays forced by the cause flag
      ctrl_r <= wdc_ctrl_t'(`WDC_CTRL_RST);
    end else begin
      ctrl_r.timeout_flag <= (ctrl_r.timeout_flag
                              && !(ctrl_wr && wd_ctrl.timeout_flag)
                              && !core_req.vector_ack)
                             || set_flag;
      if (core_req.vector_ack) begin
        ctrl_r.timeout_irq_enable <= 1'b0;
      end else if (ctrl_wr) begin
        ctrl_r.timeout_irq_enable <= wd_ctrl.timeout_irq_enable;
      end
      if (ctrl_wr && wd_ctrl.change_unlock) begin
        ctrl_r.change_unlock <= 1'b1;
      end else if (unlock_cnt_r == 3'h0) begin
        ctrl_r.change_unlock <= 1'b0;
      end
      if (ctrl_wr) begin
        // a set always lands; a clear needs the window and no cause flag
        ctrl_r.reset_enable <= wd_ctrl.reset_enable ||
          (ctrl_r.reset_enable && !(ctrl_r.change_unlock && !watchdog_reset_flag_r));
      end
      if (ctrl_wr && ctrl_r.change_unlock) begin
        ctrl_r.prescale_hi <= wd_ctrl.prescale_hi;
        ctrl_r.prescale_lo <= wd_ctrl.prescale_lo;
      end
    end
  end

  // unlock window countdown, restarted by every unlocking write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_cnt_r <= 3'h0;
    end else if (ctrl_wr && wd_ctrl.change_unlock) begin
      unlock_cnt_r <= 3'(`WDC_UNLOCK_CYCLES - 1);
    end else if (unlock_cnt_r != 3'h0) begin
      unlock_cnt_r <= unlock_cnt_r - 3'h1;
    end
  end

  // watchdog reset flag: only power-on reset or a written zero clears it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_reset_flag_r <= 1'b0;
    end else if (fire_reset) begin
      watchdog_reset_flag_r <= 1'b1;
    end else if (cause_wr && !wr_data[`WDC_BIT_WATCHDOG_RESET_FLAG]) begin
      watchdog_reset_flag_r <= 1'b0;
    end
  end

  // sticky event status, write one to clear, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= `WDC_EV_RST;
    end else begin
      stat_r[`WDC_BIT_EV_TIMEOUT] <= (stat_r[`WDC_BIT_EV_TIMEOUT] &&
        !(stat_wr && wr_data[`WDC_BIT_EV_TIMEOUT])) || set_flag;
      stat_r[`WDC_BIT_EV_RESET] <= (stat_r[`WDC_BIT_EV_RESET] &&
        !(stat_wr && wr_data[`WDC_BIT_EV_RESET])) || fire_reset;
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `WDC_EV_RST;
    end else if (mask_wr) begin
      mask_r <= wr_data[`WDC_EV_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_r & mask_r);
    end
  end

  // core side: request only while the core's global flag is up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rsp.irq_req           <= 1'b0;
      core_rsp.irq_vector_num    <= `WDC_TIMEOUT_VEC_NUM;
      core_rsp.irq_vector_addr   <= `WDC_TIMEOUT_VEC_ADDR;
      core_rsp.sys_reset_req     <= 1'b0;
      core_rsp.reset_vector_addr <= `WDC_RESET_VEC_ADDR;
    end else begin
      core_rsp.irq_req <= ctrl_r.timeout_flag && ie_eff &&
                          core_req.global_irq_en && !core_req.vector_ack;
      core_rsp.irq_vector_num    <= `WDC_TIMEOUT_VEC_NUM;
      core_rsp.irq_vector_addr   <= `WDC_TIMEOUT_VEC_ADDR;
      core_rsp.sys_reset_req     <= fire_reset;
      core_rsp.reset_vector_addr <= `WDC_RESET_VEC_ADDR;
    end
  end

  // read data mux; reads have no side effects
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `WDC_OFF_CTRL: rd_data[7:0] = {ctrl_r.timeout_flag, ie_eff, ctrl_r.prescale_hi,
        ctrl_r.change_unlock, eff_re, ctrl_r.prescale_lo};
      `WDC_OFF_CAUSE: rd_data[`WDC_BIT_WATCHDOG_RESET_FLAG] = watchdog_reset_flag_r;
      `WDC_OFF_STAT:  rd_data[`WDC_EV_W-1:0] = stat_r;
      `WDC_OFF_MASK:  rd_data[`WDC_EV_W-1:0] = mask_r;
      `WDC_OFF_CMD:   rd_data = 32'h0000_0000;
      default:        rd_hit = 1'b0;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WDC_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_hit ? `WDC_RESP_OKAY : `WDC_RESP_SLVERR;
    end
  end

  AST_IRQ_MODE_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_IRQ) && timeout |=> ctrl_r.timeout_flag && !core_rsp.sys_reset_req)
    else $error("interrupt mode time-out did not set flag");
  AST_FIRST_TIMEOUT_NO_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_IRQ_RESET) && timeout && !ctrl_r.timeout_flag
    |=> ctrl_r.timeout_flag && !core_rsp.sys_reset_req && !$rose(watchdog_reset_flag_r))
    else $error("first combined-mode time-out handled wrongly");
  AST_VECTOR_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
    core_req.vector_ack && !timeout |=> !ctrl_r.timeout_flag && !ctrl_r.timeout_irq_enable)
    else $error("vector entry did not clear enable and flag");
  AST_SECOND_TIMEOUT_RESETS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_IRQ_RESET) && timeout && ctrl_r.timeout_flag
    |=> core_rsp.sys_reset_req && watchdog_reset_flag_r ##1 !core_rsp.sys_reset_req)
    else $error("unserviced second time-out gave no reset pulse");
  AST_STOPPED_SILENT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_STOPPED) ##1 (mode == MODE_STOPPED) |-> !timeout && !core_rsp.sys_reset_req)
    else $error("stopped watchdog acted");
  AST_FUSE_FORCES_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    fuse_prog && timeout |=> core_rsp.sys_reset_req && !ctrl_r.timeout_flag)
    else $error("programmed fuse did not force reset");
  AST_PRESCALE_LOCKED: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_r.change_unlock && !fire_reset
    |=> $stable({ctrl_r.prescale_hi, ctrl_r.prescale_lo}))
    else $error("prescale changed while locked");
  // the bit drops at the fourth edge after the write, so it reads low from the fifth
  AST_UNLOCK_CLOSES: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl_wr && wd_ctrl.change_unlock && !fire_reset ##1 (!ctrl_wr && !fire_reset)[*4]
    |=> !ctrl_r.change_unlock)
    else $error("unlock window did not close after four cycles");
  AST_WATCHDOG_RESET_FLAG_KEEPS_RE: assert property (@(posedge core_clk) disable iff (!rst_n)
    watchdog_reset_flag_r && ctrl_wr && ctrl_r.reset_enable && !fire_reset |=> ctrl_r.reset_enable)
    else $error("reset enable cleared while reset flag set");
  AST_FLAG_W1C: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl_wr && wd_ctrl.timeout_flag && !set_flag |=> !ctrl_r.timeout_flag)
    else $error("writing one did not clear the flag");

endmodule

// >>> sim/wdc_core_model.sv
`timescale 1ns/1ns
module wdc_core_model import wdc_pkg::*; (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // bench control
  input  wire logic          gie,
  input  wire logic          service,
  input  wire logic          restart,
  // core link
  input  wire wdc_core_rsp_t core_rsp,
  output wdc_core_req_t      core_req
);
  logic [1:0] wait_r;
  logic       ack_r;

  // enter the vector two cycles after a request, one pulse per request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 2'h0;
      ack_r  <= 1'b0;
    end else begin
      ack_r <= (wait_r == 2'h2);
      if (wait_r != 2'h0) begin
        wait_r <= (wait_r == 2'h2) ? 2'h0 : wait_r + 2'h1;
      end else if (service && core_rsp.irq_req && !ack_r) begin
        wait_r <= 2'h1;
      end
    end
  end

  // global flag and restart pulse come straight from the bench
  assign core_req = '{vector_ack: ack_r, restart: restart, global_irq_en: gie};
endmodule

// >>> sim/wdc_watchdog_tb.sv
`timescale 1ns/1ns
module wdc_watchdog_tb import wdc_pkg::*;;
  logic core_clk = 1'b0, rst_n = 1'b0, wdt_osc_clk = 1'b0, always_on_fuse = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic gie = 1'b0, service = 1'b0, restart = 1'b0;
  wdc_core_req_t core_req;
  wdc_core_rsp_t core_rsp;
  int errors = 0, checks = 0, rst_cnt = 0, base;

  wdc_watchdog #(.BASE(4)) i_wdc_watchdog (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdt_osc_clk, .always_on_fuse, .core_req,
    .core_rsp, .irq_o);
  wdc_core_model i_wdc_core_model (.core_clk, .rst_n, .gie, .service, .restart, .core_req,
    .core_rsp);

  // slow oscillator is free running and unrelated to the core clock
  always #50 core_clk = ~core_clk;
  always #340 wdt_osc_clk = ~wdt_osc_clk; // edges never coincide with a rising core edge
  always @(posedge core_clk) if (core_rsp.sys_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;

  task automatic chk(input string n, input logic [31:0] got, input int e);
    checks++;
    if (got !== 32'(e)) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, 32'(e), got);
    end
  endtask
  // one lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int er = 0);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), er);
  endtask
  task automatic rd(input logic [7:0] a, input int e, input int er = 0);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", 32'(s_axi_rresp), er);
  endtask
  task automatic wait_rst(input int n);
    for (int i = 0; i < 400 && rst_cnt < n; i++) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // main sequence: registers, interrupt, combined, unlock, fuse, restart
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 0);
    rd(8'h04, 0);
    rd(8'h20, 0, 2); // unmapped
    wr(8'h20, 8'hFF, 2);
    wr(8'h0C, 8'h01);
    wr(8'h00, 8'h40);
    repeat (60) @(posedge core_clk);
    chk("irq_req", 32'(core_rsp.irq_req), 0);
    chk("irq_o", 32'(irq_o), 1);
    rd(8'h00, 'hC0);
    gie <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("irq_req", 32'(core_rsp.irq_req), 1);
    chk("vec_num", 32'(core_rsp.irq_vector_num), 9);
    chk("vec_addr", 32'(core_rsp.irq_vector_addr), 'h8);
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h40);
    rd(8'h00, 'hC0);
    wr(8'h00, 8'hC0);
    rd(8'h00, 'h40);
    wr(8'h0C, 8'h00);
    @(posedge core_clk);
    chk("irq_o", 32'(irq_o), 0); // masked
    wr(8'h00, 8'h80);
    wr(8'h08, 8'h03);
    rd(8'h08, 0);
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h48);
    for (int i = 0; i < 400 && core_rsp.irq_req !== 1'b1; i++) @(posedge core_clk);
    chk("irq_req", 32'(core_rsp.irq_req), 1);
    chk("resets", rst_cnt, 0);
    wait_rst(1);
    chk("resets", rst_cnt, 1);
    chk("rst_vec", 32'(core_rsp.reset_vector_addr), 0);
    rd(8'h08, 'h03);
    wr(8'h10, 8'h01);
    rd(8'h04, 'h08);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
    rd(8'h00, 'h08);
    wr(8'h04, 8'h00);
    // serviced interrupt drops back to reset mode
    service <= 1'b1;
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h48);
    for (int i = 0; i < 400 && core_rsp.irq_req !== 1'b1; i++) @(posedge core_clk);
    chk("irq_req", 32'(core_rsp.irq_req), 1);
    repeat (6) @(posedge core_clk);
    rd(8'h00, 'h08);
    base = rst_cnt;
    wait_rst(base + 1);
    chk("resets", rst_cnt, base + 1);
    wr(8'h10, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h29);
    rd(8'h00, 'h29);
    wr(8'h00, 8'h20);
    rd(8'h00, 'h29);
    wr(8'h00, 8'h39);
    repeat (2) @(posedge core_clk);
    wr(8'h00, 8'h00);
    rd(8'h00, 'h29);
    wr(8'h00, 8'h39);
    wr(8'h00, 8'h00);
    rd(8'h00, 0);
    always_on_fuse <= 1'b0;
    base = rst_cnt;
    wr(8'h00, 8'h40);
    rd(8'h00, 0);
    wait_rst(base + 1);
    chk("resets", rst_cnt, base + 1);
    always_on_fuse <= 1'b1;
    // restarts every ten cycles keep the reset away
    for (int i = 0; i < 14; i++) begin
      restart <= 1'b1;
      @(posedge core_clk);
      restart <= 1'b0;
      repeat (9) @(posedge core_clk);
      if (i == 0) base = rst_cnt;
    end
    chk("resets", rst_cnt, base);
    end_of_test();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
endmodule
